// ### qshf_top.sv
// transmit space request, group hash filter and receive low water mark
// Behaviour
// - host writes 16-bit transmit space request in double words, resets zero
// - with monitor enabled, flag space available once free space meets request
// - 64-bit hash table in four words, used only in hash-perfect mode
// - hash index is six top bits of crc over 48-bit address
// - index top two bits pick word, lower four bits pick bit
// - multicast frame accepted if selected bit set, dropped if clear
// - receive-all plus multicast-with-address accepts every multicast frame
// - 12-bit low water mark, default 0x600, upper four bits reserved
// - space available status is interrupt flag bit six
`timescale 1ns/1ps
`default_nettype none
module qshf_top
  import qshf_pkg::*;
(
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic rst_n_i, // asynchronous reset, active low
  input wire qshf_pkg::qshf_host_req_t host_req_i, // host bus access
  output qshf_pkg::qshf_host_rsp_t host_rsp_o, // registered read answer
  input wire qshf_pkg::qshf_ctrl_t ctrl_i, // neighbouring control bits
  input wire logic [15:0] tx_free_dwords_i, // free transmit queue space
  input wire logic tx_space_free_clr_i, // host clears the status flag
  output logic tx_space_free_flag_o, // sticky space available status
  input wire logic da_valid_i, // destination address present
  input wire logic [qshf_pkg::MAC_W-1:0] da_i, // received destination
  output logic decision_valid_o, // filter verdict valid, one cycle
  output logic accept_o, // frame passes the group filter
  input wire logic [11:0] rx_free_dwords_i, // free receive queue space
  output logic flow_release_o // flow control or backpressure released
);
  import qshf_pkg::*;

  logic [DATA_W-1:0] tx_space_request_q;
  logic [DATA_W-1:0] hash_q [HASH_WORDS];
  logic [LOW_MARK_W-1:0] rx_low_mark_value_q;
  qshf_txm_state_t txm_q;
  logic tx_space_free_flag_q;
  logic decision_valid_q;
  logic accept_q;
  logic flow_release_q;
  qshf_host_rsp_t rsp_q;
  logic mon_en_q;

  logic [ADDR_W-1:0] word_addr;
  logic hit_tx;
  logic hit_low;
  logic [HASH_WORDS-1:0] hit_hash;
  logic [HASH_IDX_W-1:0] hash_idx;
  logic hash_bit;
  logic is_mcast;
  logic bypass_all;
  logic tx_ge;
  logic rx_gt;
  logic space_set;
  logic arm;
  logic accept_d;

  // address decode on the even byte address of each word
  assign word_addr = {host_req_i.addr[ADDR_W-1:1], 1'b0};
  assign hit_tx = word_addr == TX_SPACE_REQ_OFS;
  assign hit_low = word_addr == RX_LOW_MARK_OFS;
  assign hit_hash[0] = word_addr == HASH_WORD0_OFS;
  assign hit_hash[1] = word_addr == HASH_WORD1_OFS;
  assign hit_hash[2] = word_addr == HASH_WORD2_OFS;
  assign hit_hash[3] = word_addr == HASH_WORD3_OFS;

  // transmit space request, byte lanes written separately
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_space_request_q <= TX_SPACE_REQ_RST;
    end else if (host_req_i.wr && hit_tx) begin
      if (host_req_i.be[0]) begin
        tx_space_request_q[7:0] <= host_req_i.wdata[7:0];
      end
      if (host_req_i.be[1]) begin
        tx_space_request_q[15:8] <= host_req_i.wdata[15:8];
      end
    end
  end

  // group hash table, four 16-bit words
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < HASH_WORDS; i++) begin
        hash_q[i] <= HASH_WORD_RST;
      end
    end else if (host_req_i.wr) begin
      for (int i = 0; i < HASH_WORDS; i++) begin
        if (hit_hash[i] && host_req_i.be[0]) begin
          hash_q[i][7:0] <= host_req_i.wdata[7:0];
        end
        if (hit_hash[i] && host_req_i.be[1]) begin
          hash_q[i][15:8] <= host_req_i.wdata[15:8];
        end
      end
    end
  end

  // low water mark, reserved top nibble is not stored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_low_mark_value_q <= LOW_MARK_RST;
    end else if (host_req_i.wr && hit_low) begin
      if (host_req_i.be[0]) begin
        rx_low_mark_value_q[7:0] <= host_req_i.wdata[7:0];
      end
      if (host_req_i.be[1]) begin
        rx_low_mark_value_q[11:8] <= host_req_i.wdata[11:8];
      end
    end
  end

  // read answer, unmapped words read as zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsp_q <= '0;
    end else begin
      rsp_q.valid <= host_req_i.rd;
      if (!host_req_i.rd) begin
        rsp_q.rdata <= RDATA_NONE;
      end else if (hit_tx) begin
        rsp_q.rdata <= tx_space_request_q;
      end else if (hit_low) begin
        rsp_q.rdata <= {4'h0, rx_low_mark_value_q};
      end else if (hit_hash[0]) begin
        rsp_q.rdata <= hash_q[0];
      end else if (hit_hash[1]) begin
        rsp_q.rdata <= hash_q[1];
      end else if (hit_hash[2]) begin
        rsp_q.rdata <= hash_q[2];
      end else if (hit_hash[3]) begin
        rsp_q.rdata <= hash_q[3];
      end else begin
        rsp_q.rdata <= RDATA_NONE;
      end
    end
  end

  // space comparison for transmit, low mark comparison for receive
  qshf_space_cmp #(
    .W(DATA_W)
  ) u_tx_cmp (
    .free_i(tx_free_dwords_i),
    .level_i(tx_space_request_q),
    .ge_o(tx_ge),
    .gt_o()
  );

  qshf_space_cmp #(
    .W(LOW_MARK_W)
  ) u_rx_cmp (
    .free_i(rx_free_dwords_i),
    .level_i(rx_low_mark_value_q),
    .ge_o(),
    .gt_o(rx_gt)
  );

  // monitor arms on enable rising or on a new request write
  assign arm = ctrl_i.tx_mon_en &&
               (!mon_en_q || (host_req_i.wr && hit_tx));
  assign space_set = (txm_q == TXM_ARMED) && ctrl_i.tx_mon_en && tx_ge;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mon_en_q <= 1'b0;
    end else begin
      mon_en_q <= ctrl_i.tx_mon_en;
    end
  end

  // one status event per armed request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txm_q <= TXM_IDLE;
    end else begin
      unique case (txm_q)
        TXM_IDLE: begin
          if (arm) begin
            txm_q <= TXM_ARMED;
          end
        end
        TXM_ARMED: begin
          if (!ctrl_i.tx_mon_en || (space_set && !arm)) begin
            txm_q <= TXM_IDLE;
          end
        end
      endcase
    end
  end

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_space_free_flag_q <= 1'b0;
    end else begin
      tx_space_free_flag_q <= space_set ||
        (tx_space_free_flag_q && !tx_space_free_clr_i);
    end
  end

  // group filter verdict
  qshf_hash_index u_hash (
    .da_i(da_i),
    .idx_o(hash_idx)
  );

  assign hash_bit = hash_q[hash_idx[HASH_SEL_HI:HASH_SEL_LO]]
                          [hash_idx[HASH_BIT_HI:0]];
  assign is_mcast = da_i[GROUP_BIT];
  assign bypass_all = ctrl_i.rx_all && ctrl_i.mcast_addr_filt;
  assign accept_d = !is_mcast || !ctrl_i.hash_mode
                    || bypass_all || hash_bit;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      decision_valid_q <= 1'b0;
      accept_q <= 1'b0;
    end else begin
      decision_valid_q <= da_valid_i;
      if (da_valid_i) begin
        accept_q <= accept_d;
      end
    end
  end

  // release flow control while free space is above the low mark
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flow_release_q <= 1'b0;
    end else begin
      flow_release_q <= rx_gt;
    end
  end

  assign host_rsp_o = rsp_q;
  assign tx_space_free_flag_o = tx_space_free_flag_q;
  assign decision_valid_o = decision_valid_q;
  assign accept_o = accept_q;
  assign flow_release_o = flow_release_q;

  // checks on the block's own behaviour
  sequence full_req_write_s;
    host_req_i.wr && hit_tx && host_req_i.be == 2'b11;
  endsequence

  sequence low_mark_read_s;
    host_req_i.rd && hit_low && !host_req_i.wr;
  endsequence

  req_write_lands_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    full_req_write_s |=> tx_space_request_q == $past(host_req_i.wdata))
    else $error("space request not stored");

  space_flag_sets_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    txm_q == TXM_ARMED && ctrl_i.tx_mon_en && tx_ge
    |=> tx_space_free_flag_o)
    else $error("space flag missed");

  flag_has_cause_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(tx_space_free_flag_o) |-> $past(ctrl_i.tx_mon_en)
    && $past(tx_ge))
    else $error("space flag without cause");

  set_beats_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    space_set && tx_space_free_clr_i |=> tx_space_free_flag_o)
    else $error("space event lost to clear");

  flag_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_space_free_clr_i && !space_set |=> !tx_space_free_flag_o)
    else $error("space flag not cleared");

  hash_mode_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    da_valid_i && !ctrl_i.hash_mode |=> decision_valid_o && accept_o)
    else $error("frame dropped outside hash mode");

  hash_bit_verdict_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    da_valid_i && ctrl_i.hash_mode && is_mcast && !bypass_all
    |=> accept_o == $past(hash_q[hash_idx[HASH_SEL_HI:HASH_SEL_LO]]
                                [hash_idx[HASH_BIT_HI:0]]))
    else $error("hash verdict wrong");

  bypass_accepts_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    da_valid_i && is_mcast && ctrl_i.rx_all && ctrl_i.mcast_addr_filt
    |=> accept_o)
    else $error("multicast dropped under receive all");

  mark_reads_back_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    low_mark_read_s |=> host_rsp_o.valid && host_rsp_o.rdata[15:12] == 4'h0
    && host_rsp_o.rdata[11:0] == $past(rx_low_mark_value_q))
    else $error("low mark read wrong");

  flow_follows_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> flow_release_o ==
    $past(rx_free_dwords_i > rx_low_mark_value_q))
    else $error("flow release does not follow the low mark");

  verdict_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    1'b1 |=> decision_valid_o == $past(da_valid_i))
    else $error("filter verdict not one cycle after address");

  monitor_disarm_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ctrl_i.tx_mon_en |=> txm_q == TXM_IDLE)
    else $error("space monitor armed while disabled");
endmodule
`default_nettype wire

// ### qshf_pkg.sv
// shared constants and types for the queue space and hash filter block
package qshf_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MAC_W = 48;
  localparam int unsigned GROUP_BIT = 40;
  localparam int unsigned HASH_IDX_W = 6;
  localparam int unsigned HASH_WORDS = 4;
  localparam int unsigned HASH_SEL_HI = 5;
  localparam int unsigned HASH_SEL_LO = 4;
  localparam int unsigned HASH_BIT_HI = 3;
  localparam int unsigned LOW_MARK_W = 12;
  localparam int unsigned CRC_W = 32;
  // register byte addresses on the parallel host bus
  localparam logic [11:0] TX_SPACE_REQ_OFS = 12'h19E;
  localparam logic [11:0] HASH_WORD0_OFS = 12'h1A0;
  localparam logic [11:0] HASH_WORD1_OFS = 12'h1A2;
  localparam logic [11:0] HASH_WORD2_OFS = 12'h1A4;
  localparam logic [11:0] HASH_WORD3_OFS = 12'h1A6;
  localparam logic [11:0] RX_LOW_MARK_OFS = 12'h1B0;
  // reset values
  localparam logic [15:0] TX_SPACE_REQ_RST = 16'h0000;
  localparam logic [15:0] HASH_WORD_RST = 16'h0000;
  localparam logic [11:0] LOW_MARK_RST = 12'h600;
  localparam logic [15:0] RDATA_NONE = 16'h0000;
  // frame check sequence generator
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;

  // one host bus access, taken in the cycle wr or rd is high
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [1:0] be;
    logic [DATA_W-1:0] wdata;
  } qshf_host_req_t;

  // read answer, one cycle after the read strobe
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] rdata;
  } qshf_host_rsp_t;

  // control bits that live in neighbouring registers
  typedef struct packed {
    logic tx_mon_en;
    logic hash_mode;
    logic rx_all;
    logic mcast_addr_filt;
  } qshf_ctrl_t;

  typedef enum logic {
    TXM_IDLE,
    TXM_ARMED
  } qshf_txm_state_t;
endpackage

// ### qshf_hash_index.sv
// hash index from the frame check sequence of a destination address
`timescale 1ns/1ps
`default_nettype none
module qshf_hash_index
  import qshf_pkg::*;
(
  input wire logic [qshf_pkg::MAC_W-1:0] da_i, // destination address
  output logic [qshf_pkg::HASH_IDX_W-1:0] idx_o // six-bit table index
);
  // first octet is da_i[47:40], each octet fed least significant bit first
  function automatic logic [CRC_W-1:0] crc_of(input logic [MAC_W-1:0] d);
    logic [CRC_W-1:0] c;
    logic fb;
    c = CRC_INIT;
    fb = 1'b0;
    for (int o = 0; o < MAC_W / 8; o++) begin
      for (int b = 0; b < 8; b++) begin
        fb = c[CRC_W-1] ^ d[MAC_W - 8 * (o + 1) + b];
        c = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
      end
    end
    return c;
  endfunction

  logic [CRC_W-1:0] crc;

  // six most significant crc bits form the index
  assign crc = crc_of(da_i);
  assign idx_o = crc[CRC_W-1 -: HASH_IDX_W];
endmodule
`default_nettype wire

// ### qshf_space_cmp.sv
// compares a free space level against a programmed amount
`timescale 1ns/1ps
`default_nettype none
module qshf_space_cmp #(
  parameter int unsigned W = 16
) (
  input wire logic [W-1:0] free_i, // free space, double words
  input wire logic [W-1:0] level_i, // programmed amount
  output logic ge_o, // free space at or above the amount
  output logic gt_o // free space strictly above the amount
);
  // both relations are needed by different users
  assign ge_o = free_i >= level_i;
  assign gt_o = free_i > level_i;
endmodule
`default_nettype wire

// ### qshf_host_model.sv
// host processor model that drives the parallel register bus
`timescale 1ns/1ps
`default_nettype none
module qshf_host_model
  import qshf_pkg::*;
(
  input wire logic clk_i, // system clock
  output var qshf_pkg::qshf_host_req_t req_o // bus access to the block
);
  import qshf_pkg::*;

  // bus starts quiet
  initial req_o = '0;

  // one access, launched just after an edge and held over the next edge
  task automatic acc(input logic w, input logic r, input logic [11:0] a,
                     input logic [15:0] d, input logic [1:0] b);
    req_o.wr = w;
    req_o.rd = r;
    req_o.addr = a;
    req_o.be = b;
    req_o.wdata = d;
    @(posedge clk_i);
    #1;
  endtask

  // a released bus shows inverted leftovers, never the last value
  task automatic idle();
    req_o.wr = 1'b0;
    req_o.rd = 1'b0;
    req_o.addr = ~req_o.addr;
    req_o.be = ~req_o.be;
    req_o.wdata = ~req_o.wdata;
    @(posedge clk_i);
    #1;
  endtask
endmodule
`default_nettype wire

// ### qshf_top_tb.sv
// self-checking testbench for the queue space and hash filter block
`timescale 1ns/1ps
`default_nettype none
module qshf_top_tb;
  import qshf_pkg::*;
  logic clk, rst_n, clr, flag, da_v, dec_v, acc, rel;
  qshf_host_req_t req;
  qshf_host_rsp_t rsp;
  qshf_ctrl_t ctrl;
  logic [15:0] tx_free;
  logic [47:0] da;
  logic [11:0] rx_free;
  logic [5:0] ix;
  int n_errors, cmp_count;
  integer seed = 32'h4412;
  logic [15:0] rq[$];
  logic fq[$];
  logic [15:0] ht[4];
  logic [11:0] fv[4] = '{12'h100, 12'h101, 12'hFFF, 12'h000};
  logic fe[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

  qshf_host_model host (.clk_i(clk), .req_o(req));
  qshf_top uut (.clk_i(clk), .rst_n_i(rst_n), .host_req_i(req),
    .host_rsp_o(rsp), .ctrl_i(ctrl), .tx_free_dwords_i(tx_free),
    .tx_space_free_clr_i(clr), .tx_space_free_flag_o(flag),
    .da_valid_i(da_v), .da_i(da), .decision_valid_o(dec_v),
    .accept_o(acc), .rx_free_dwords_i(rx_free), .flow_release_o(rel));

  // clock at 100 MHz
  always #5 clk = ~clk;

  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    rq.push_back(e);
    host.acc(1'b0, 1'b1, a, 16'h0000, 2'b11);
  endtask

  task automatic wrb(input logic [11:0] a, input logic [15:0] d,
                     input logic [1:0] b);
    host.acc(1'b1, 1'b0, a, d, b);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    wrb(a, d, 2'b11);
  endtask

  // crc over the address, octets in order, each least bit first
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    logic fb;
    c = 32'hFFFF_FFFF;
    for (int i = 0; i < 6; i++) begin
      for (int b = 0; b < 8; b++) begin
        fb = c[31] ^ a[40-8*i+b];
        c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
      end
    end
    return c[31:26];
  endfunction

  task automatic wait_flag(input logic v, input int n);
    for (int i = 0; i < n && flag !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(flag === v, "space flag level");
  endtask

  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // take the oldest note whenever an answer or a verdict appears
  always @(posedge clk) begin
    if (rsp.valid === 1'b1) begin
      if (rq.size() == 0) chk(1'b0, "unexpected read answer");
      else chk(rsp.rdata === rq.pop_front(), "read data");
    end else if (rst_n === 1'b1) begin
      chk(rsp.rdata === 16'h0000, "idle read data");
    end
    if (dec_v === 1'b1) begin
      if (fq.size() == 0) chk(1'b0, "unexpected verdict");
      else chk(acc === fq.pop_front(), "filter verdict");
    end
  end

  // a hang is cut short here
  initial begin
    #100000;
    chk(1'b0, "run timed out");
    give_verdict();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ctrl = '0;
    tx_free = 16'h0000;
    clr = 1'b0;
    da_v = 1'b0;
    da = '0;
    rx_free = 12'h000;
    n_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    // reset values, unmapped place included
    rd(TX_SPACE_REQ_OFS, 16'h0000);
    for (int k = 0; k < 4; k++) rd(HASH_WORD0_OFS + 12'(2*k), 16'h0000);
    rd(RX_LOW_MARK_OFS, 16'h0600);
    rd(12'h1A8, 16'h0000);
    // random writes and readback, back to back
    ht[0] = 16'($random(seed));
    wr(TX_SPACE_REQ_OFS, ht[0]);
    rd(TX_SPACE_REQ_OFS, ht[0]);
    for (int k = 0; k < 4; k++) begin
      ht[k] = 16'($random(seed));
      wr(HASH_WORD0_OFS + 12'(2*k), ht[k]);
    end
    // single byte lanes, and a write with no lane selected
    wrb(HASH_WORD1_OFS, 16'h5AC3, 2'b01);
    wrb(HASH_WORD2_OFS, 16'h5AC3, 2'b10);
    wrb(HASH_WORD3_OFS, 16'h5AC3, 2'b00);
    ht[1][7:0] = 8'hC3;
    ht[2][15:8] = 8'h5A;
    for (int k = 0; k < 4; k++) rd(HASH_WORD0_OFS + 12'(2*k), ht[k]);
    wr(RX_LOW_MARK_OFS, 16'hF123);
    rd(RX_LOW_MARK_OFS, 16'h0123);
    wr(12'h1A8, 16'hFFFF);
    rd(12'h1A8, 16'h0000);
    host.idle();
    // every filter mode, back to back addresses, last one unicast
    for (int m = 0; m < 8; m++) begin
      ctrl.hash_mode = m[0];
      ctrl.rx_all = m[1];
      ctrl.mcast_addr_filt = m[2];
      for (int j = 0; j < 8; j++) begin
        da = 48'({$random(seed), $random(seed)});
        da[40] = (j != 7);
        ix = hidx(da);
        da_v = 1'b1;
        fq.push_back(!da[40] || !ctrl.hash_mode || (ctrl.rx_all && ctrl.mcast_addr_filt) || ht[ix[5:4]][ix[3:0]]);
        @(posedge clk);
        #1;
      end
    end
    da_v = 1'b0;
    // space monitor: one short of the request, then exactly it
    wr(TX_SPACE_REQ_OFS, 16'h0064);
    host.idle();
    tx_free = 16'h0063;
    ctrl.tx_mon_en = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(flag === 1'b0, "flag below request");
    tx_free = 16'h0064;
    wait_flag(1'b1, 4);
    clr = 1'b1;
    @(posedge clk);
    #1;
    clr = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(flag === 1'b0, "one event per arming");
    wr(TX_SPACE_REQ_OFS, 16'h0064);
    host.idle();
    wait_flag(1'b1, 4);
    // re-arm while the host holds the clear: the set must win
    clr = 1'b1;
    @(posedge clk);
    #1;
    wr(TX_SPACE_REQ_OFS, 16'h0064);
    chk(flag === 1'b0, "flag held by clear");
    host.idle();
    clr = 1'b0;
    wait_flag(1'b1, 4);
    // low water mark against free receive space
    wr(RX_LOW_MARK_OFS, 16'h0100);
    host.idle();
    for (int k = 0; k < 4; k++) begin
      rx_free = fv[k];
      repeat (2) @(posedge clk);
      #1;
      chk(rel === fe[k], "flow release");
    end
    // reset in mid run
    rst_n = 1'b0;
    @(posedge clk);
    #1;
    chk(flag === 1'b0 && rel === 1'b0, "outputs in reset");
    rst_n = 1'b1;
    rd(RX_LOW_MARK_OFS, 16'h0600);
    host.idle();
    repeat (3) @(posedge clk);
    chk(rq.size() == 0 && fq.size() == 0, "answers missing");
    give_verdict();
  end
endmodule
`default_nettype wire
